/* src/dvsr_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module dvsr_i2c_slave
    import dvsr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = SERIAL_ADDR_DEFAULT
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_rd_data,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    output logic [7:0] o_ptr,
    output dvsr_wr_t o_wr
);
    // ==========================================================
    // Pin synchronisers and line events
    // ==========================================================
    logic scl_meta, scl_q, scl_d, sda_meta, sda_q, sda_d;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            {scl_meta, scl_q, scl_d} <= 3'h7;
            {sda_meta, sda_q, sda_d} <= 3'h7;
        end
        else
        begin
            {scl_meta, scl_q, scl_d} <= {i_scl, scl_meta, scl_q};
            {sda_meta, sda_q, sda_d} <= {i_sda, sda_meta, sda_q};
        end
    end
    wire logic scl_rise = scl_q & ~scl_d;
    wire logic scl_fall = ~scl_q & scl_d;
    wire logic bus_start = scl_q & scl_d & sda_d & ~sda_q;
    wire logic bus_stop = scl_q & scl_d & ~sda_d & sda_q;

    // ==========================================================
    // Byte engine
    // ==========================================================
    dvsr_ser_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rw_reg, nack_reg;
    wire logic byte_done = (bit_cnt_reg == 4'h8);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            state_reg <= SER_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            nack_reg <= 1'b1;
            o_ptr <= 8'h00;
            o_sda_oe_n <= 1'b1;
            o_sda_out <= 1'b0;
            o_wr <= '0;
        end
        else
        begin
            o_wr.stb <= 1'b0;
            if (bus_start)
            begin
                state_reg <= SER_ADDR;
                bit_cnt_reg <= 4'h0;
                o_sda_oe_n <= 1'b1;
            end
            else if (bus_stop)
            begin
                state_reg <= SER_IDLE;
                o_sda_oe_n <= 1'b1;
            end
            else if (scl_rise)
            begin
                case (state_reg)
                    SER_ADDR, SER_REG, SER_WDATA:
                    begin
                        shift_reg <= {shift_reg[6:0], sda_q};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    SER_RDATA: bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    SER_RACK: nack_reg <= sda_q;
                    default: ;
                endcase
            end
            else if (scl_fall)
            begin
                case (state_reg)
                    SER_ADDR:
                        if (byte_done)
                        begin
                            if (shift_reg[7:1] == DEV_ADDR)
                            begin
                                state_reg <= SER_ACK_ADDR;
                                rw_reg <= shift_reg[0];
                                o_sda_oe_n <= 1'b0;
                            end
                            else
                                state_reg <= SER_IDLE;
                        end
                    SER_REG:
                        if (byte_done)
                        begin
                            o_ptr <= shift_reg;
                            state_reg <= SER_ACK_REG;
                            o_sda_oe_n <= 1'b0;
                        end
                    SER_WDATA:
                        if (byte_done)
                        begin
                            o_wr <= '{stb: 1'b1, addr: o_ptr, data: shift_reg};
                            state_reg <= SER_ACK_WDATA;
                            o_sda_oe_n <= 1'b0;
                        end
                    SER_ACK_ADDR:
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg)
                        begin
                            state_reg <= SER_RDATA;
                            shift_reg <= i_rd_data;
                            o_sda_oe_n <= i_rd_data[7];
                        end
                        else
                        begin
                            state_reg <= SER_REG;
                            o_sda_oe_n <= 1'b1;
                        end
                    end
                    SER_ACK_REG, SER_ACK_WDATA:
                    begin
                        // Auto-increment lets a burst fill consecutive registers
                        if (state_reg == SER_ACK_WDATA)
                            o_ptr <= o_ptr + 8'h01;
                        state_reg <= SER_WDATA;
                        bit_cnt_reg <= 4'h0;
                        o_sda_oe_n <= 1'b1;
                    end
                    SER_RDATA:
                        if (byte_done)
                        begin
                            state_reg <= SER_RACK;
                            o_ptr <= o_ptr + 8'h01;
                            o_sda_oe_n <= 1'b1;
                        end
                        else
                        begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            o_sda_oe_n <= shift_reg[6];
                        end
                    SER_RACK:
                        if (!nack_reg)
                        begin
                            state_reg <= SER_RDATA;
                            bit_cnt_reg <= 4'h0;
                            shift_reg <= i_rd_data;
                            o_sda_oe_n <= i_rd_data[7];
                        end
                        else
                            state_reg <= SER_IDLE;
                    default: ;
                endcase
            end
        end
    end
endmodule : dvsr_i2c_slave
`default_nettype wire

/* src/dvsr_pkg.sv */
// ==========================================================
// Register map and field layout
// ==========================================================
package dvsr_pkg;
    localparam logic [7:0] ADDR_SETPOINT_ZERO = 8'h00;
    localparam logic [7:0] ADDR_SETPOINT_ONE = 8'h01;
    localparam logic [7:0] ADDR_SETPOINT_TWO = 8'h02;
    localparam logic [7:0] ADDR_SETPOINT_THREE = 8'h03;
    localparam logic [7:0] ADDR_PIN_PULLDOWN_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_THERMAL_STATUS_CONTROL = 8'h05;
    localparam logic [7:0] ADDR_SLEW_CONTROL = 8'h06;
    localparam logic [7:0] ADDR_RESERVED_SLOT = 8'h07;
    localparam logic [7:0] ADDR_IDENTIFICATION_LOW = 8'h08;
    localparam logic [7:0] ADDR_IDENTIFICATION_HIGH = 8'h09;

    // Setpoint reset values, wide-code variant then narrow-code variant
    localparam logic [7:0] RST_SETPOINT_ZERO_7B = 8'h2e;
    localparam logic [7:0] RST_SETPOINT_ONE_7B = 8'h5a;
    localparam logic [7:0] RST_SETPOINT_TWO_7B = 8'h42;
    localparam logic [7:0] RST_SETPOINT_THREE_7B = 8'h42;
    localparam logic [7:0] RST_SETPOINT_ZERO_6B = 8'h3f;
    localparam logic [7:0] RST_SETPOINT_ONE_6B = 8'h17;
    localparam logic [7:0] RST_SETPOINT_TWO_6B = 8'h3f;
    localparam logic [7:0] RST_SETPOINT_THREE_6B = 8'h21;
    localparam logic [7:0] RST_PIN_PULLDOWN_CONTROL = 8'he0;
    localparam logic [7:0] RST_THERMAL_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_SLEW_CONTROL = 8'h00;

    // Field positions and writable masks
    localparam int MODE_BIT = 7;
    localparam int ENABLE_PIN_PULLDOWN_BIT = 7;
    localparam int SELECT_LOW_PULLDOWN_BIT = 6;
    localparam int SELECT_HIGH_PULLDOWN_BIT = 5;
    localparam int THERMAL_SHUTDOWN_DISABLE_BIT = 2;
    localparam int THERMAL_EARLY_WARNING_BIT = 1;
    localparam int THERMAL_SHUTDOWN_FLAG_BIT = 0;
    localparam int SLEW_CODE_MSB = 7;
    localparam int SLEW_CODE_LSB = 5;
    localparam int OUTPUT_DISCHARGE_ENABLE_BIT = 2;
    localparam int FORCED_RAMP_DOWN_BIT = 1;
    localparam logic [7:0] SETPOINT_MASK_7B = 8'hff;
    localparam logic [7:0] SETPOINT_MASK_6B = 8'hbf;
    localparam logic [7:0] PULLDOWN_MASK = 8'he0;
    localparam logic [7:0] SLEW_MASK = 8'he6;

    // Voltage target arithmetic in mV
    localparam logic [10:0] STEP_MV = 11'h00a;
    localparam logic [10:0] BASE_MV_7B = 11'h1f4;
    localparam logic [10:0] BASE_MV_6B = 11'h302;

    // Arbitrary neutral values: serial address and identification
    localparam logic [6:0] SERIAL_ADDR_DEFAULT = 7'h60;
    localparam logic [7:0] IDENT_LOW_DEFAULT = 8'ha5;
    localparam logic [7:0] IDENT_HIGH_DEFAULT = 8'h3c;

    typedef enum logic [3:0] {
        SER_IDLE = 4'b0000,
        SER_ADDR = 4'b0001,
        SER_ACK_ADDR = 4'b0010,
        SER_REG = 4'b0011,
        SER_ACK_REG = 4'b0100,
        SER_WDATA = 4'b0101,
        SER_ACK_WDATA = 4'b0110,
        SER_RDATA = 4'b0111,
        SER_RACK = 4'b1000
    } dvsr_ser_state_t;

    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } dvsr_wr_t;

    typedef struct packed {
        logic forced_pwm;
        logic [6:0] code;
    } dvsr_applied_t;
endpackage : dvsr_pkg

/* src/dvsr_setpoint_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module dvsr_setpoint_bank
    import dvsr_pkg::*;
#(
    parameter bit WIDE_CODE = 1'b1,
    parameter logic [6:0] DEV_ADDR = SERIAL_ADDR_DEFAULT,
    parameter logic [7:0] IDENT_LOW = IDENT_LOW_DEFAULT,
    parameter logic [7:0] IDENT_HIGH = IDENT_HIGH_DEFAULT
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_select_pin_low_bit,
    input wire logic i_select_pin_high_bit,
    input wire logic i_thermal_trip,
    input wire logic i_thermal_warn,
    output dvsr_applied_t o_applied,
    output logic [10:0] o_target_mv,
    output logic o_enable_pin_pulldown,
    output logic o_select_low_pulldown,
    output logic o_select_high_pulldown,
    output logic o_thermal_shutdown,
    output logic [2:0] o_slew_code,
    output logic o_output_discharge_enable,
    output logic o_forced_ramp_down_light_load
);
    // ==========================================================
    // Serial port
    // ==========================================================
    dvsr_wr_t wr;
    logic [7:0] ptr;
    logic [7:0] rd_data;

    dvsr_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_serial (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_rd_data(rd_data),
        .o_sda_out(o_sda_out),
        .o_sda_oe_n(o_sda_oe_n),
        .o_ptr(ptr),
        .o_wr(wr)
    );

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] sel_meta, sel_q;
    logic trip_meta, trip_q, warn_meta, warn_q;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            {sel_meta, sel_q} <= 4'h0;
            {trip_meta, trip_q, warn_meta, warn_q} <= 4'h0;
        end
        else
        begin
            sel_meta <= {i_select_pin_high_bit, i_select_pin_low_bit};
            sel_q <= sel_meta;
            {trip_meta, trip_q} <= {i_thermal_trip, trip_meta};
            {warn_meta, warn_q} <= {i_thermal_warn, warn_meta};
        end
    end

    // ==========================================================
    // Register file
    // ==========================================================
    localparam logic [7:0] SETPOINT_MASK = WIDE_CODE ? SETPOINT_MASK_7B : SETPOINT_MASK_6B;
    localparam logic [10:0] BASE_MV = WIDE_CODE ? BASE_MV_7B : BASE_MV_6B;
    localparam logic [7:0] RST_SP0 = WIDE_CODE ? RST_SETPOINT_ZERO_7B : RST_SETPOINT_ZERO_6B;
    localparam logic [7:0] RST_SP1 = WIDE_CODE ? RST_SETPOINT_ONE_7B : RST_SETPOINT_ONE_6B;
    localparam logic [7:0] RST_SP2 = WIDE_CODE ? RST_SETPOINT_TWO_7B : RST_SETPOINT_TWO_6B;
    localparam logic [7:0] RST_SP3 = WIDE_CODE ? RST_SETPOINT_THREE_7B : RST_SETPOINT_THREE_6B;

    logic [7:0] setpoint_reg [4];
    logic [7:0] pulldown_reg;
    logic [7:0] slew_reg;
    logic ts_disable_reg;
    logic ts_flag_reg;

    wire logic wr_pulldown = wr.stb && (wr.addr == ADDR_PIN_PULLDOWN_CONTROL);
    wire logic wr_thermal = wr.stb && (wr.addr == ADDR_THERMAL_STATUS_CONTROL);
    wire logic wr_slew = wr.stb && (wr.addr == ADDR_SLEW_CONTROL);
    // Writing zero to the flag clears it; writing one has no effect
    wire logic ts_clear = wr_thermal && !wr.data[THERMAL_SHUTDOWN_FLAG_BIT];
    wire logic ts_event = trip_q && !ts_disable_reg;
    wire logic ts_flag_next = ts_event || (ts_flag_reg && !ts_clear);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            setpoint_reg[0] <= RST_SP0 & SETPOINT_MASK;
            setpoint_reg[1] <= RST_SP1 & SETPOINT_MASK;
            setpoint_reg[2] <= RST_SP2 & SETPOINT_MASK;
            setpoint_reg[3] <= RST_SP3 & SETPOINT_MASK;
            pulldown_reg <= RST_PIN_PULLDOWN_CONTROL;
            slew_reg <= RST_SLEW_CONTROL;
            ts_disable_reg <= RST_THERMAL_STATUS_CONTROL[THERMAL_SHUTDOWN_DISABLE_BIT];
            ts_flag_reg <= RST_THERMAL_STATUS_CONTROL[THERMAL_SHUTDOWN_FLAG_BIT];
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                if (wr.stb && wr.addr == 8'(i))
                    setpoint_reg[i] <= wr.data & SETPOINT_MASK;
            if (wr_pulldown)
                pulldown_reg <= wr.data & PULLDOWN_MASK;
            if (wr_slew)
                slew_reg <= wr.data & SLEW_MASK;
            if (wr_thermal)
                ts_disable_reg <= wr.data[THERMAL_SHUTDOWN_DISABLE_BIT];
            ts_flag_reg <= ts_flag_next;
        end
    end

    wire logic [7:0] thermal_read = {5'h00, ts_disable_reg, warn_q, ts_flag_reg};
    assign rd_data = (ptr <= ADDR_SETPOINT_THREE) ? setpoint_reg[ptr[1:0]]
                   : (ptr == ADDR_PIN_PULLDOWN_CONTROL) ? pulldown_reg
                   : (ptr == ADDR_THERMAL_STATUS_CONTROL) ? thermal_read
                   : (ptr == ADDR_SLEW_CONTROL) ? slew_reg
                   : (ptr == ADDR_IDENTIFICATION_LOW) ? IDENT_LOW
                   : (ptr == ADDR_IDENTIFICATION_HIGH) ? IDENT_HIGH
                   : 8'h00;

    // ==========================================================
    // Applied setpoint
    // ==========================================================
    // Re-evaluated every cycle, so pin changes and writes need no trigger
    wire logic [7:0] selected = setpoint_reg[sel_q];
    wire logic [6:0] selected_code = selected[6:0];
    wire logic [10:0] target_next = 11'(BASE_MV + {4'h0, selected_code} * STEP_MV);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            o_applied <= '0;
            o_target_mv <= BASE_MV;
            o_enable_pin_pulldown <= RST_PIN_PULLDOWN_CONTROL[ENABLE_PIN_PULLDOWN_BIT];
            o_select_low_pulldown <= RST_PIN_PULLDOWN_CONTROL[SELECT_LOW_PULLDOWN_BIT];
            o_select_high_pulldown <= RST_PIN_PULLDOWN_CONTROL[SELECT_HIGH_PULLDOWN_BIT];
            o_thermal_shutdown <= 1'b0;
            o_slew_code <= 3'h0;
            o_output_discharge_enable <= 1'b0;
            o_forced_ramp_down_light_load <= 1'b0;
        end
        else
        begin
            o_applied <= '{forced_pwm: selected[MODE_BIT], code: selected_code};
            o_target_mv <= target_next;
            o_enable_pin_pulldown <= pulldown_reg[ENABLE_PIN_PULLDOWN_BIT];
            o_select_low_pulldown <= pulldown_reg[SELECT_LOW_PULLDOWN_BIT];
            o_select_high_pulldown <= pulldown_reg[SELECT_HIGH_PULLDOWN_BIT];
            o_thermal_shutdown <= ts_flag_reg;
            o_slew_code <= slew_reg[SLEW_CODE_MSB:SLEW_CODE_LSB];
            o_output_discharge_enable <= slew_reg[OUTPUT_DISCHARGE_ENABLE_BIT];
            o_forced_ramp_down_light_load <= slew_reg[FORCED_RAMP_DOWN_BIT];
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_apply_set_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_reset_n && sel_q == 2'b00) |=> (o_applied == $past(setpoint_reg[0])))
        else $error("setpoint zero not applied");
    a_apply_set_one: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_reset_n && sel_q == 2'b01) |=> (o_applied == $past(setpoint_reg[1])))
        else $error("setpoint one not applied");
    a_apply_set_two: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_reset_n && sel_q == 2'b10) |=> (o_applied == $past(setpoint_reg[2])))
        else $error("setpoint two not applied");
    a_apply_set_three: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_reset_n && sel_q == 2'b11) |=> (o_applied == $past(setpoint_reg[3])))
        else $error("setpoint three not applied");
    a_mode_bit_follows: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr.stb && wr.addr == {6'h00, sel_q} ##1 (!wr.stb && $stable(sel_q)))
        |=> (o_applied.forced_pwm == $past(wr.data[MODE_BIT], 2)))
        else $error("forced mode bit not applied");
    a_target_formula: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $past(i_reset_n) |-> (o_target_mv == 11'(BASE_MV + {4'h0, o_applied.code} * STEP_MV)))
        else $error("voltage target does not match code");
    a_reserved_bit_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !WIDE_CODE |-> (o_applied.code[6] == 1'b0 && setpoint_reg[ptr[1:0]][6] == 1'b0))
        else $error("reserved bit six has effect");
    a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (ts_flag_reg && !ts_clear) |=> ts_flag_reg)
        else $error("shutdown flag lost without clear");
    a_flag_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        ts_event |=> ts_flag_reg ##1 o_thermal_shutdown)
        else $error("shutdown event lost");
    a_pulldown_write: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_pulldown |-> ##2 ({o_enable_pin_pulldown, o_select_low_pulldown, o_select_high_pulldown}
        == $past(wr.data[7:5], 2)))
        else $error("pulldown enables not applied");
    a_shutdown_masked: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (ts_disable_reg && !ts_flag_reg && !wr_thermal) |=> !ts_flag_reg)
        else $error("shutdown flagged while disabled");
    a_write_applies: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr.stb && wr.addr == {6'h00, sel_q} ##1 (!wr.stb && $stable(sel_q)))
        |=> (o_applied.code == $past(wr.data[6:0] & SETPOINT_MASK[6:0], 2)))
        else $error("write to active setpoint not applied");
endmodule : dvsr_setpoint_bank
`default_nettype wire

/* tb/dvsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Processor side: open-drain serial master
// ==========================================================
module dvsr_host
(
    input wire logic i_sys_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_drv
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end
    // Eight cycles a phase, twice what the synchronisers need
    task automatic half();
        repeat (8) @(posedge i_sys_clk);
    endtask : half
    // Start or repeated start; stop when end_bus is set
    task automatic frame(input logic end_bus);
        half();
        o_sda_drv <= end_bus ? 1'b0 : 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_drv <= end_bus ? 1'b1 : 1'b0;
        half();
        if (!end_bus)
            o_scl <= 1'b0;
    endtask : frame
    // Data moves well after the falling edge, never while clock is high
    task automatic bit_io(input logic b, output logic r);
        half();
        o_sda_drv <= b;
        half();
        o_scl <= 1'b1;
        half();
        r = i_sda;
        o_scl <= 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(last, ack);
    endtask : xfer
    task automatic access(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, input logic rd,
        output logic [7:0] q, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        frame(1'b0);
        xfer({dev, 1'b0}, 1'b1, r, k0);
        xfer(a, 1'b1, r, k1);
        if (rd)
            frame(1'b0);
        xfer(rd ? {dev, 1'b1} : d, 1'b1, r, k2);
        k3 = 1'b0;
        if (rd)
            xfer(8'hff, 1'b1, q, k3);
        frame(1'b1);
        ok = !(k0 | k1 | k2);
    endtask : access
endmodule : dvsr_host
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dvsr_pkg::*;
    localparam logic [6:0] WA = 7'h60;
    localparam logic [6:0] NA = 7'h61;
    localparam logic [7:0] RW [4] = '{8'h2e, 8'h5a, 8'h42, 8'h42};
    localparam logic [7:0] RN [4] = '{8'h3f, 8'h17, 8'h3f, 8'h21};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sel_lo = 1'b0, sel_hi = 1'b0, trip = 1'b0, warn = 1'b0;
    logic scl, sda_drv, so_w, oe_w, so_n, oe_n, enable_pin_pulldown, pd_lo, pd_hi, tsd, disc, rmpd;
    logic [10:0] mv_w, mv_n;
    logic [2:0] slew;
    dvsr_applied_t app_w, app_n;
    int miscompares = 0;
    int tests_run = 0;
    // Pull-up: any party may pull the line low
    wire logic sda = sda_drv & (oe_w | so_w) & (oe_n | so_n);
    always #5 clk = ~clk;
    dvsr_host host (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_drv(sda_drv));
    dvsr_setpoint_bank #(.WIDE_CODE(1'b1), .DEV_ADDR(WA)) dut (.i_sys_clk(clk), .i_reset_n(reset_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(so_w), .o_sda_oe_n(oe_w), .i_select_pin_low_bit(sel_lo),
        .i_select_pin_high_bit(sel_hi), .i_thermal_trip(trip), .i_thermal_warn(warn), .o_applied(app_w),
        .o_target_mv(mv_w), .o_enable_pin_pulldown(enable_pin_pulldown), .o_select_low_pulldown(pd_lo),
        .o_select_high_pulldown(pd_hi), .o_thermal_shutdown(tsd), .o_slew_code(slew),
        .o_output_discharge_enable(disc), .o_forced_ramp_down_light_load(rmpd));
    // Narrow-code part on the same bus, so address refusal is exercised too
    dvsr_setpoint_bank #(.WIDE_CODE(1'b0), .DEV_ADDR(NA)) dut_narrow (.i_sys_clk(clk), .i_reset_n(reset_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(so_n), .o_sda_oe_n(oe_n), .i_select_pin_low_bit(sel_lo),
        .i_select_pin_high_bit(sel_hi), .i_thermal_trip(trip), .i_thermal_warn(warn), .o_applied(app_n),
        .o_target_mv(mv_n), .o_enable_pin_pulldown(), .o_select_low_pulldown(), .o_select_high_pulldown(),
        .o_thermal_shutdown(), .o_slew_code(), .o_output_discharge_enable(), .o_forced_ramp_down_light_load());
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        host.access(dev, a, 8'h00, 1'b1, q, ok);
        chk({2'b00, ok, q}, {3'b001, exp}, "register read");
    endtask : rd
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, input logic exp_ok);
        logic [7:0] q;
        logic ok;
        host.access(dev, a, d, 1'b0, q, ok);
        chk({10'h000, ok}, {10'h000, exp_ok}, "write acknowledge");
        repeat (4) @(posedge clk);
    endtask : wr
    task automatic app(input logic [7:0] w, input logic [7:0] n);
        chk({3'b000, app_w}, {3'b000, w}, "wide applied");
        chk(mv_w, BASE_MV_7B + 11'(w[6:0]) * STEP_MV, "wide target");
        chk({4'h0, app_n.forced_pwm, app_n.code[5:0]}, {4'h0, n[7], n[5:0]}, "narrow applied");
        chk(mv_n, BASE_MV_6B + 11'(n[5:0]) * STEP_MV, "narrow target");
    endtask : app
    task automatic t_reset();
        for (int a = 0; a < 4; a++)
        begin
            rd(WA, 8'(a), RW[a]);
            rd(NA, 8'(a), RN[a]);
        end
        rd(WA, 8'h04, 8'he0);
        rd(WA, 8'h05, 8'h00);
        rd(WA, 8'h06, 8'h00);
        chk({8'h00, enable_pin_pulldown, pd_lo, pd_hi}, 11'h007, "pulldown defaults");
        $display("test reset values done");
    endtask : t_reset
    task automatic t_select();
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            {sel_hi, sel_lo} <= 2'(s);
            repeat (4) @(posedge clk);
            app(RW[s], RN[s]);
        end
        $display("test select pins done");
    endtask : t_select
    task automatic t_write();
        wr(WA, 8'h03, 8'hff, 1'b1);
        wr(NA, 8'h03, 8'hff, 1'b1);
        app(8'hff, 8'hff);
        rd(NA, 8'h03, 8'hbf);
        wr(WA, 8'h03, 8'h00, 1'b1);
        wr(WA, 8'h00, 8'h11, 1'b1);
        app(8'h00, 8'hff);
        rd(WA, 8'h00, 8'h11);
        wr(WA, 8'h07, 8'h55, 1'b1);
        rd(WA, 8'h07, 8'h00);
        wr(7'h22, 8'h00, 8'h00, 1'b0);
        $display("test live writes done");
    endtask : t_write
    task automatic t_thermal();
        trip <= 1'b1;
        repeat (6) @(posedge clk);
        trip <= 1'b0;
        repeat (6) @(posedge clk);
        chk({10'h000, tsd}, 11'h001, "shutdown latched");
        rd(WA, 8'h05, 8'h01);
        wr(WA, 8'h05, 8'h01, 1'b1);
        chk({10'h000, tsd}, 11'h001, "flag kept");
        wr(WA, 8'h05, 8'h04, 1'b1);
        chk({10'h000, tsd}, 11'h000, "flag cleared");
        trip <= 1'b1;
        warn <= 1'b1;
        repeat (6) @(posedge clk);
        chk({10'h000, tsd}, 11'h000, "shutdown disabled");
        rd(WA, 8'h05, 8'h06);
        trip <= 1'b0;
        warn <= 1'b0;
        $display("test thermal done");
    endtask : t_thermal
    task automatic t_ctrl();
        wr(WA, 8'h04, 8'h5f, 1'b1);
        chk({8'h00, enable_pin_pulldown, pd_lo, pd_hi}, 11'h002, "pulldown bits");
        rd(WA, 8'h04, 8'h40);
        wr(WA, 8'h06, 8'hff, 1'b1);
        chk({6'h00, slew, disc, rmpd}, 11'h01f, "slew outputs");
        rd(WA, 8'h06, 8'he6);
        $display("test control done");
    endtask : t_ctrl
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_select();
        t_write();
        t_thermal();
        t_ctrl();
        final_report();
    end
    // About 25k cycles expected; well beyond that means a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
